/* startup_cfg_pkg.sv */
// Purpose: constants and types for the motor start-up configuration bank
// Assumes: 32-bit register port, word-aligned byte offsets
// Notes: field positions follow the start-up settings word layout
package startup_cfg_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] STARTUP_ALIGN_OFFSET = 8'h84;
  localparam logic [ADDR_W-1:0] CLOSED_LOOP_A_OFFSET = 8'h88;

  // Reset values
  localparam logic [DATA_W-1:0] STARTUP_ALIGN_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CLOSED_LOOP_A_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 32'h0000_0000;

  // Field positions in the start-up settings word
  localparam int ALIGN_ANGLE_LSB = 8;
  localparam int ALIGN_ANGLE_W = 5;
  localparam int FIRST_PCT_LSB = 4;
  localparam int FIRST_PCT_W = 4;
  localparam int RATE_CHOICE_BIT = 3;
  localparam int THETA_RAMP_LSB = 0;
  localparam int THETA_RAMP_W = 3;

  // Upper bits of the start-up word that are stored but not decoded here
  localparam int STARTUP_UPPER_LSB = 13;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Decoded start-up fields
  typedef struct packed {
    logic [ALIGN_ANGLE_W-1:0] align_angle_code;
    logic [FIRST_PCT_W-1:0] startup_first_cycle_pct;
    logic first_cycle_rate_choice;
    logic [THETA_RAMP_W-1:0] theta_ramp_code;
  } startup_fields_t;

endpackage

/* cfg_word_store.sv */
// Purpose: one 32-bit configuration word with reset value and write port
// Assumes: synchronous write, asynchronous active-low reset
// Notes: read data come straight from the stored flip-flops
`timescale 1ns/1ps
module cfg_word_store
  import startup_cfg_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Write side
  input wire logic i_we,
  input wire logic [WIDTH-1:0] i_wdata,
  // Stored word
  output logic [WIDTH-1:0] o_word
);

  logic [WIDTH-1:0] word_reg;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      word_reg <= RESET_VALUE;
    end else if (i_we) begin
      word_reg <= i_wdata;
    end
  end

  assign o_word = word_reg;

endmodule // cfg_word_store

/* motor_startup_config_fields.sv */
// Purpose: start-up and closed-loop configuration register bank
// Assumes: one-cycle strobes; read data valid the cycle after a read strobe
// Notes: fields are plain storage decoded onto outputs for the start-up logic
//
// How it works
// [R01] Bits 12:8 select rotor alignment angle
// [R02] Bits 7:4 set first-cycle speed percent
// [R03] Bit 3 picks 0 Hz or percent
// [R04] Bits 2:0 set angle error ramp rate
// [R05] Closed-loop word at 88h, resets zero
// [R06] Reads return last write, no side effects
`timescale 1ns/1ps
module motor_startup_config_fields
  import startup_cfg_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  // Decoded start-up fields
  output logic [ALIGN_ANGLE_W-1:0] o_align_angle_code,
  output logic [FIRST_PCT_W-1:0] o_startup_first_cycle_pct,
  output logic o_first_cycle_rate_choice,
  output logic o_first_cycle_zero_hz,
  output logic [THETA_RAMP_W-1:0] o_theta_ramp_code,
  // Closed-loop settings word
  output logic [DATA_W-1:0] o_closed_loop_settings_a
);

  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic rst_n;
  reg_req_t req;
  logic we_startup;
  logic we_closed;
  logic [DATA_W-1:0] startup_word;
  logic [DATA_W-1:0] closed_word;
  logic [DATA_W-1:0] rdata_next;
  startup_fields_t fields;

  // Reset release through two flops
  always_ff @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end

  assign rst_n = rst_sync2_reg;

  assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    return a == off;
  endfunction

  assign we_startup = req.wr && hit(req.addr, STARTUP_ALIGN_OFFSET);
  // [R05] closed-loop decode
  assign we_closed = req.wr && hit(req.addr, CLOSED_LOOP_A_OFFSET);

  // [R06] plain word storage
  cfg_word_store #(
    .WIDTH(DATA_W),
    .RESET_VALUE(STARTUP_ALIGN_RESET)
  ) u_startup_word (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_we(we_startup),
    .i_wdata(req.wdata),
    .o_word(startup_word)
  );

  // [R05] zero reset word
  cfg_word_store #(
    .WIDTH(DATA_W),
    .RESET_VALUE(CLOSED_LOOP_A_RESET)
  ) u_closed_word (
    .i_clock(i_clock),
    .i_rst_n(rst_n),
    .i_we(we_closed),
    .i_wdata(req.wdata),
    .o_word(closed_word)
  );

  // [R01] alignment angle slice
  assign fields.align_angle_code = startup_word[ALIGN_ANGLE_LSB +: ALIGN_ANGLE_W];
  // [R02] first-cycle percent slice
  assign fields.startup_first_cycle_pct = startup_word[FIRST_PCT_LSB +: FIRST_PCT_W];
  // [R03] rate choice bit
  assign fields.first_cycle_rate_choice = startup_word[RATE_CHOICE_BIT];
  // [R04] theta ramp slice
  assign fields.theta_ramp_code = startup_word[THETA_RAMP_LSB +: THETA_RAMP_W];

  // [R06] read-back mux
  always_comb begin
    rdata_next = UNMAPPED_READ;
    if (hit(req.addr, STARTUP_ALIGN_OFFSET)) begin
      rdata_next = startup_word;
    end else if (hit(req.addr, CLOSED_LOOP_A_OFFSET)) begin
      rdata_next = closed_word;
    end
  end

  // Read data held for exactly the cycle after the strobe
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_rdata <= UNMAPPED_READ;
    end else if (req.rd) begin
      o_rdata <= rdata_next;
    end else begin
      o_rdata <= UNMAPPED_READ;
    end
  end

  // Field outputs registered from the stored words
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      o_align_angle_code <= STARTUP_ALIGN_RESET[ALIGN_ANGLE_LSB +: ALIGN_ANGLE_W];
      o_startup_first_cycle_pct <= STARTUP_ALIGN_RESET[FIRST_PCT_LSB +: FIRST_PCT_W];
      o_first_cycle_rate_choice <= STARTUP_ALIGN_RESET[RATE_CHOICE_BIT];
      o_first_cycle_zero_hz <= ~STARTUP_ALIGN_RESET[RATE_CHOICE_BIT];
      o_theta_ramp_code <= STARTUP_ALIGN_RESET[THETA_RAMP_LSB +: THETA_RAMP_W];
      o_closed_loop_settings_a <= CLOSED_LOOP_A_RESET;
    end else begin
      o_align_angle_code <= fields.align_angle_code;
      o_startup_first_cycle_pct <= fields.startup_first_cycle_pct;
      o_first_cycle_rate_choice <= fields.first_cycle_rate_choice;
      // [R03] zero forces 0 Hz
      o_first_cycle_zero_hz <= ~fields.first_cycle_rate_choice;
      o_theta_ramp_code <= fields.theta_ramp_code;
      o_closed_loop_settings_a <= closed_word;
    end
  end

endmodule // motor_startup_config_fields

/* motor_startup_config_fields_properties.sv */
// Purpose: bound checks for the start-up configuration bank
// Assumes: field outputs follow a write two edges later
// Notes: sees top ports only
`timescale 1ns/1ps
module motor_startup_config_fields_properties
  import startup_cfg_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rstn,
  // Register port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  // Outputs
  input wire logic [ALIGN_ANGLE_W-1:0] o_align_angle_code,
  input wire logic [FIRST_PCT_W-1:0] o_startup_first_cycle_pct,
  input wire logic o_first_cycle_rate_choice,
  input wire logic o_first_cycle_zero_hz,
  input wire logic [THETA_RAMP_W-1:0] o_theta_ramp_code,
  input wire logic [DATA_W-1:0] o_closed_loop_settings_a
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  wire wa = i_wr && i_addr == STARTUP_ALIGN_OFFSET;
  wire wc = i_wr && i_addr == CLOSED_LOOP_A_OFFSET;
  angle_field_a: assert property (wa |-> ##2 o_align_angle_code == $past(i_wdata[12:8], 2))
    else $error("align angle wrong");
  pct_field_a: assert property (wa |-> ##2 o_startup_first_cycle_pct == $past(i_wdata[7:4], 2))
    else $error("first cycle pct wrong");
  rate_choice_a: assert property (wa |-> ##2 o_first_cycle_rate_choice == $past(i_wdata[3], 2)
    && o_first_cycle_zero_hz != $past(i_wdata[3], 2)) else $error("rate choice wrong");
  ramp_field_a: assert property (wa |-> ##2 o_theta_ramp_code == $past(i_wdata[2:0], 2))
    else $error("ramp code wrong");
  closed_word_a: assert property (wc |-> ##2 o_closed_loop_settings_a == $past(i_wdata, 2))
    else $error("closed loop word wrong");
  idle_rdata_a: assert property (!$past(i_rd) |-> o_rdata == '0)
    else $error("read data outside read");
  closed_read_a: assert property (i_rd && i_addr == CLOSED_LOOP_A_OFFSET && !$past(i_wr)
    |=> o_rdata == $past(o_closed_loop_settings_a)) else $error("closed loop readback wrong");
  cover property (wa);
  cover property (wc ##1 i_rd);
  cover property (i_rd ##1 i_rd);
endmodule // motor_startup_config_fields_properties

bind motor_startup_config_fields motor_startup_config_fields_properties u_props (.*);

/* tb_motor_startup_config_fields.sv */
// Purpose: self-checking bench for the start-up configuration bank
// Assumes: read data stand in the cycle after the strobe
// Notes: start-up field outputs are judged here after each read of 84h, the closed-loop word after each read of 88h, and also by the bound checker
`timescale 1ns/1ps
module tb_motor_startup_config_fields;
  import startup_cfg_pkg::*;
  logic i_clock = 0, i_rstn = 0, i_wr = 0, i_rd = 0, rd_d = 0;
  logic [ADDR_W-1:0] i_addr = '0, ca;
  logic [ADDR_W-1:0] a_q[$];
  logic [DATA_W-1:0] i_wdata = '0, w, c, o_rdata, o_closed_loop_settings_a;
  logic [DATA_W-1:0] exp_q[$];
  logic [ALIGN_ANGLE_W-1:0] o_align_angle_code;
  logic [FIRST_PCT_W-1:0] o_startup_first_cycle_pct;
  logic o_first_cycle_rate_choice, o_first_cycle_zero_hz;
  logic [THETA_RAMP_W-1:0] o_theta_ramp_code;
  int fails = 0, checks_done = 0;
  motor_startup_config_fields u_dut (.*);
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Read notes its expected word
  task automatic op(input logic we, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clock);
    i_wr <= we;
    i_rd <= !we;
    i_addr <= a;
    i_wdata <= d;
    if (!we) begin
      exp_q.push_back(d);
      a_q.push_back(a);
    end
  endtask
  initial begin
    forever #4 i_clock = ~i_clock;
  end
  initial begin
    #16000;
    fails++;
    conclude();
  end
  always @(posedge i_clock) rd_d <= i_rd;
  always @(negedge i_clock) begin
    if (rd_d) begin
      c = exp_q.pop_front();
      ca = a_q.pop_front();
      checks_done++;
      if (o_rdata !== c) begin
        fails++;
        $display("[ERR] o_rdata exp %h got %h", c, o_rdata);
      end
      // Decoded outputs must match the word just read back
      if (ca == STARTUP_ALIGN_OFFSET) begin
        checks_done++;
        if ({o_align_angle_code, o_startup_first_cycle_pct, o_first_cycle_rate_choice, o_theta_ramp_code,
            o_first_cycle_zero_hz} !== {c[12:0], ~c[3]}) begin
          fails++;
          $display("[ERR] start-up fields exp %h got %h", {c[12:0], ~c[3]}, {o_align_angle_code,
              o_startup_first_cycle_pct, o_first_cycle_rate_choice, o_theta_ramp_code, o_first_cycle_zero_hz});
        end
      end
      if (ca == CLOSED_LOOP_A_OFFSET) begin
        checks_done++;
        if (o_closed_loop_settings_a !== c) begin
          fails++;
          $display("[ERR] o_closed_loop_settings_a exp %h got %h", c, o_closed_loop_settings_a);
        end
      end
    end
  end
  initial begin
    void'($urandom(32'h8BAA));
    repeat (20) @(posedge i_clock);
    i_rstn <= 1;
    repeat (3) @(posedge i_clock);
    op(0, CLOSED_LOOP_A_OFFSET, CLOSED_LOOP_A_RESET);
    op(0, STARTUP_ALIGN_OFFSET, STARTUP_ALIGN_RESET);
    // Every code of every field
    for (int i = 0; i < 32; i++) begin
      w = $urandom();
      w[12:0] = {i[4:0], i[3:0], i[0], i[2:0]};
      op(1, STARTUP_ALIGN_OFFSET, w);
      op(1, CLOSED_LOOP_A_OFFSET, ~w);
      op(0, CLOSED_LOOP_A_OFFSET, ~w);
      op(1, 8'h80, -w);
      op(0, STARTUP_ALIGN_OFFSET, w);
      op(0, 8'h80, UNMAPPED_READ);
    end
    @(posedge i_clock);
    i_rd <= 0;
    repeat (4) @(posedge i_clock);
    // Mid-run reset must bring both words back to zero
    i_rstn <= 0;
    repeat (3) @(posedge i_clock);
    i_rstn <= 1;
    repeat (3) @(posedge i_clock);
    op(0, CLOSED_LOOP_A_OFFSET, CLOSED_LOOP_A_RESET);
    op(0, STARTUP_ALIGN_OFFSET, STARTUP_ALIGN_RESET);
    @(posedge i_clock);
    i_rd <= 0;
    repeat (4) @(posedge i_clock);
    conclude();
  end
endmodule // tb_motor_startup_config_fields
